/* rtl/operation_command_decoder.sv */
// operation byte register, margin decode and conversion on/off sequencing
module operation_command_decoder
    import opcmd_pkg::*;
#(
    parameter logic [6:0] ADDR = BUS_ADDR_DEF
) (
    // clock, reset, enable
    input  wire logic                    clk_sys_i,
    input  wire logic                    nrst_i,
    input  wire logic                    ce_i,
    // management bus pins
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe_n_o,
    output logic                         alert_o,
    output logic                         alert_oe_n_o,
    // status and enable configuration
    input  wire logic                    status_clear_i,
    input  wire logic                    cmd_respect_i,
    input  wire logic                    start_ok_i,
    // turn-off timing and regulator feedback
    input  wire logic [HOLD_W-1:0]       hold_cycles_i,
    input  wire logic                    out_at_zero_i,
    // regulation control
    output logic                         convert_o,
    output logic                         stage_hiz_o,
    output logic                         ramp_down_o,
    output opcmd_pkg::target_sel_t       target_sel_o,
    output logic                         fault_ignore_o,
    output logic                         invalid_data_o
);
    import opcmd_pkg::*;

    // conversion sequencing states
    typedef enum logic [1:0] {
        PW_OFF, PW_RUN, PW_HOLD, PW_RAMP
    } pwr_state_t;

    reg_bus_if   bus ();                   // target to register path
    logic [5:0]  op_q,   op_d;             // stored bits 7:2
    logic        inv_q,  inv_d;            // unsupported data status
    target_sel_t tgt_q,  tgt_d;            // selected voltage target
    logic        ign_q,  ign_d;            // fault-ignore qualifier
    pwr_state_t  pw_q,   pw_d;             // conversion state
    logic [HOLD_W-1:0] hcnt_q, hcnt_d;     // turn-off hold counter
    logic        wr_ok;                    // write carries a listed value
    logic        en_bit, soft_bit;         // views of the stored byte
    logic [3:0]  margin;                   // view of the margin field
    logic        run_req;                  // effective on request

    // serial target
    smbus_byte_target #(
        .ADDR (ADDR)
    ) u_target (
        .clk_sys_i  (clk_sys_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_o      (sda_o),
        .sda_oe_n_o (sda_oe_n_o),
        .bus        (bus.target)
    );

    // write check: listed margin and zero low bits
    assign wr_ok = margin_valid(bus.wr_data[MARGIN_MSB:MARGIN_LSB]) &&
                   (bus.wr_data[1:0] == LOW_BITS_VALUE);
    assign en_bit   = op_q[BIT_ENABLE - MARGIN_LSB];
    assign soft_bit = op_q[BIT_SOFT_OFF - MARGIN_LSB];
    assign margin   = op_q[MARGIN_MSB - MARGIN_LSB:0];
    // readback with low bits forced to zero
    assign bus.rd_data = {op_q, LOW_BITS_VALUE};

    // register byte, status flag and decoded outputs
    always_comb begin
        op_d  = op_q;
        inv_d = inv_q;
        if (status_clear_i) begin
            inv_d = 1'b0;
        end
        if (bus.wr_stb) begin
            if (wr_ok) begin
                // accepted: takes effect at once
                op_d = bus.wr_data[7:2];
            end else begin
                // rejected: byte kept, status set wins over clear
                inv_d = 1'b1;
            end
        end
        // target and qualifier from the value being stored
        tgt_d = margin_target(
            op_d[MARGIN_MSB - MARGIN_LSB:0]);
        ign_d = op_d[BIT_ENABLE - MARGIN_LSB] &&
                margin_ignores(
                    op_d[MARGIN_MSB - MARGIN_LSB:0]);
        if (!ce_i) begin
            op_d  = op_q;
            inv_d = inv_q;
            tgt_d = tgt_q;
            ign_d = ign_q;
        end
    end

    // enable bit counts only when the command is respected
    assign run_req = cmd_respect_i ? en_bit : 1'b1;

    // conversion sequencing
    always_comb begin
        pw_d   = pw_q;
        hcnt_d = hcnt_q;
        case (pw_q)
            PW_OFF: begin
                if (run_req && start_ok_i) begin
                    pw_d = PW_RUN;
                end
            end
            PW_RUN: begin
                if (!start_ok_i) begin
                    pw_d = PW_OFF;
                end else if (!run_req) begin
                    // falling enable picks the turn-off profile
                    pw_d   = soft_bit ? PW_HOLD : PW_OFF;
                    hcnt_d = '0;
                end
            end
            PW_HOLD: begin
                if (!start_ok_i) begin
                    pw_d = PW_OFF;
                end else if (run_req) begin
                    pw_d = PW_RUN;
                end else if (hcnt_q >= hold_cycles_i) begin
                    pw_d = PW_RAMP;
                end else begin
                    hcnt_d = hcnt_q + 1'b1;
                end
            end
            PW_RAMP: begin
                if (!start_ok_i || out_at_zero_i) begin
                    pw_d = PW_OFF;
                end else if (run_req) begin
                    pw_d = PW_RUN;
                end
            end
            default: begin
                pw_d = PW_OFF;
            end
        endcase
        if (!ce_i) begin
            pw_d   = pw_q;
            hcnt_d = hcnt_q;
        end
    end

    // registers of the decoder
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_q   <= OPER_RESET;
            inv_q  <= 1'b0;
            tgt_q  <= TGT_NOMINAL;
            ign_q  <= 1'b0;
            pw_q   <= PW_OFF;
            hcnt_q <= '0;
        end else begin
            op_q   <= op_d;
            inv_q  <= inv_d;
            tgt_q  <= tgt_d;
            ign_q  <= ign_d;
            pw_q   <= pw_d;
            hcnt_q <= hcnt_d;
        end
    end

    // outputs
    assign convert_o      = (pw_q != PW_OFF);
    assign stage_hiz_o    = (pw_q == PW_OFF);
    assign ramp_down_o    = (pw_q == PW_RAMP);
    assign target_sel_o   = tgt_q;
    assign fault_ignore_o = ign_q;
    assign invalid_data_o = inv_q;
    // alert pulled low while unsupported data is flagged
    assign alert_o        = 1'b0;
    assign alert_oe_n_o   = ~inv_q;

    // checks
    sequence s_soft_fall;
        ce_i && pw_q == PW_RUN && start_ok_i && cmd_respect_i &&
        !en_bit && soft_bit;
    endsequence

    sequence s_hard_fall;
        ce_i && pw_q == PW_RUN && start_ok_i && cmd_respect_i &&
        !en_bit && !soft_bit;
    endsequence

    AST_LOW_BITS_ZERO: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        bus.rd_data[1:0] == 2'h0)
        else $error("low bits of operation byte read nonzero");

    AST_REJECT_KEEPS: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ce_i && bus.wr_stb && !wr_ok |=>
        $stable(op_q) && inv_q && !alert_oe_n_o)
        else $error("unsupported write not rejected");

    AST_ACCEPT_LOADS: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ce_i && bus.wr_stb && wr_ok |=> op_q == $past(bus.wr_data[7:2]))
        else $error("accepted write not stored");

    AST_TARGET_FOLLOWS: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ce_i && bus.wr_stb && wr_ok |=>
        target_sel_o == margin_target($past(bus.wr_data[5:2])))
        else $error("target select does not follow margin write");

    AST_IGNORE_NEEDS_EN: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        fault_ignore_o |-> en_bit && margin_ignores(margin))
        else $error("fault ignore without enable or ignore margin");

    AST_HARD_OFF: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        s_hard_fall |=> !convert_o && stage_hiz_o)
        else $error("immediate off did not stop conversion");

    AST_SOFT_OFF: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        s_soft_fall |=> convert_o && !ramp_down_o)
        else $error("soft off did not keep regulating");

    AST_NO_START: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !convert_o && !start_ok_i |=> !convert_o)
        else $error("conversion started without start conditions");

    AST_CMD_IGNORED: assert property (
        @(posedge clk_sys_i) disable iff (!nrst_i)
        pw_q == PW_RUN && !cmd_respect_i && start_ok_i |=> convert_o)
        else $error("enable bit acted on while command ignored");
endmodule

/* rtl/opcmd_pkg.sv */
// constants, types and decode helpers for the operation command decoder
package opcmd_pkg;
    // command code of the operation byte on the management bus
    localparam logic [7:0] CMD_OPERATION   = 8'h01;
    // default 7-bit bus address of the target
    localparam logic [6:0] BUS_ADDR_DEF    = 7'h24;
    // field positions inside the operation byte
    localparam int         BIT_ENABLE      = 7;
    localparam int         BIT_SOFT_OFF    = 6;
    localparam int         MARGIN_MSB      = 5;
    localparam int         MARGIN_LSB      = 2;
    // reset value of the stored bits 7:2
    localparam logic [5:0] OPER_RESET      = 6'h00;
    // read-only low bits always return zero
    localparam logic [1:0] LOW_BITS_VALUE  = 2'h0;
    // margin state encodings
    localparam logic [3:0] MARGIN_OFF_A    = 4'h0;
    localparam logic [3:0] MARGIN_OFF_B    = 4'h1;
    localparam logic [3:0] MARGIN_OFF_C    = 4'h2;
    localparam logic [3:0] MARGIN_LOW_IGN  = 4'h5;
    localparam logic [3:0] MARGIN_LOW_ACT  = 4'h6;
    localparam logic [3:0] MARGIN_HIGH_IGN = 4'h9;
    localparam logic [3:0] MARGIN_HIGH_ACT = 4'ha;
    // width of the turn-off hold counter
    localparam int         HOLD_W          = 16;
    // bit counter value at which a byte is complete
    localparam logic [3:0] BYTE_BITS       = 4'h8;

    // output voltage target selection
    typedef enum logic [1:0] {
        TGT_NOMINAL,
        TGT_LOW,
        TGT_HIGH
    } target_sel_t;

    // true for every listed margin code
    function automatic logic margin_valid(input logic [3:0] m);
        case (m)
            MARGIN_OFF_A, MARGIN_OFF_B, MARGIN_OFF_C,
            MARGIN_LOW_IGN, MARGIN_LOW_ACT,
            MARGIN_HIGH_IGN, MARGIN_HIGH_ACT: margin_valid = 1'b1;
            default:                          margin_valid = 1'b0;
        endcase
    endfunction

    // target chosen by a margin code
    function automatic target_sel_t margin_target(input logic [3:0] m);
        case (m)
            MARGIN_LOW_IGN, MARGIN_LOW_ACT:   margin_target = TGT_LOW;
            MARGIN_HIGH_IGN, MARGIN_HIGH_ACT: margin_target = TGT_HIGH;
            default:                          margin_target = TGT_NOMINAL;
        endcase
    endfunction

    // margin codes that ask for over/under-voltage faults to be ignored
    function automatic logic margin_ignores(input logic [3:0] m);
        margin_ignores = (m == MARGIN_LOW_IGN) || (m == MARGIN_HIGH_IGN);
    endfunction
endpackage

/* rtl/reg_bus_if.sv */
// byte access path between the bus target and the register logic
interface reg_bus_if;
    logic       wr_stb;  // one-cycle pulse: a complete write byte arrived
    logic [7:0] wr_data; // data byte of that write
    logic [7:0] rd_data; // current readback of the operation byte

    // serial target side
    modport target (
        output wr_stb,
        output wr_data,
        input  rd_data
    );
    // register side
    modport regs (
        input  wr_stb,
        input  wr_data,
        output rd_data
    );
endinterface

/* rtl/smbus_byte_target.sv */
// serial byte target: write byte and read byte at the operation command
module smbus_byte_target
    import opcmd_pkg::*;
#(
    parameter logic [6:0] ADDR = BUS_ADDR_DEF
) (
    // clock, reset, enable
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    // serial pins, data is open drain
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    // register side
    reg_bus_if.target bus
);
    // transfer phases
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RACK, ST_RDATA, ST_SKIP
    } xfer_state_t;

    logic [2:0]  scl_q,   scl_d;   // scl synchroniser and edge stage
    logic [2:0]  sda_q,   sda_d;   // sda synchroniser and edge stage
    xfer_state_t st_q,    st_d;    // transfer phase
    logic [7:0]  shf_q,   shf_d;   // shift register
    logic [3:0]  cnt_q,   cnt_d;   // bits seen in current byte
    logic        slot_q,  slot_d;  // inside the ninth (ack) bit
    logic        drv_q,   drv_d;   // pull sda low
    logic        cmd_q,   cmd_d;   // command byte accepted
    logic        pend_q,  pend_d;  // write data waiting for stop
    logic [7:0]  wdat_q,  wdat_d;  // captured write data
    logic        stb_q,   stb_d;   // write strobe to registers
    logic        rise, fall, start, stop;
    logic [7:0]  byte_in;

    // edges from the second and third stages only
    assign rise    = scl_q[1] & ~scl_q[2];
    assign fall    = ~scl_q[1] & scl_q[2];
    assign start   = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop    = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    assign byte_in = {shf_q[6:0], sda_q[1]};

    // next-state logic of the byte engine
    always_comb begin
        scl_d  = {scl_q[1:0], scl_i};
        sda_d  = {sda_q[1:0], sda_i};
        st_d   = st_q;
        shf_d  = shf_q;
        cnt_d  = cnt_q;
        slot_d = slot_q;
        drv_d  = drv_q;
        cmd_d  = cmd_q;
        pend_d = pend_q;
        wdat_d = wdat_q;
        stb_d  = 1'b0;
        if (start) begin
            // start or repeated start: keep the accepted command
            st_d   = ST_ADDR;
            cnt_d  = '0;
            slot_d = 1'b0;
            drv_d  = 1'b0;
        end else if (stop) begin
            // write takes effect at stop, then bus is free
            stb_d  = pend_q;
            st_d   = ST_IDLE;
            cmd_d  = 1'b0;
            pend_d = 1'b0;
            drv_d  = 1'b0;
        end else if (rise && !slot_q && cnt_q != BYTE_BITS) begin
            cnt_d = cnt_q + 4'h1;
            if (st_q == ST_RDATA) begin
                // next read bit moves to the top
                shf_d = {shf_q[6:0], 1'b0};
            end else begin
                shf_d = byte_in;
            end
            if (cnt_q == BYTE_BITS - 4'h1) begin
                case (st_q)
                    ST_ADDR: begin
                        if (byte_in[7:1] != ADDR) begin
                            st_d = ST_SKIP;
                        end else if (!byte_in[0]) begin
                            st_d = ST_CMD;
                        end else begin
                            // read address: ack first, data after
                            st_d = cmd_q ? ST_RACK : ST_SKIP;
                        end
                    end
                    ST_CMD: begin
                        // only the operation command is answered
                        cmd_d = (byte_in == CMD_OPERATION);
                        st_d  = cmd_d ? ST_WDATA : ST_SKIP;
                    end
                    ST_WDATA: begin
                        wdat_d = byte_in;
                        pend_d = 1'b1;
                        st_d   = ST_SKIP;
                    end
                    default: begin
                        st_d = st_q;
                    end
                endcase
            end
        end else if (fall) begin
            if (slot_q) begin
                // end of ack bit: release, start next byte
                slot_d = 1'b0;
                cnt_d  = '0;
                drv_d  = 1'b0;
                if (st_q == ST_RACK) begin
                    // read address acked: present the byte
                    st_d  = ST_RDATA;
                    shf_d = bus.rd_data;
                    drv_d = ~bus.rd_data[7];
                end
            end else if (cnt_q == BYTE_BITS) begin
                // ack bit: acknowledge when a byte was kept
                slot_d = 1'b1;
                drv_d  = (st_q == ST_CMD) || (st_q == ST_WDATA) ||
                         (st_q == ST_RACK) ||
                         (st_q == ST_SKIP && pend_q && cnt_q == BYTE_BITS
                          && wdat_q == shf_q);
                if (st_q == ST_RDATA) begin
                    drv_d = 1'b0;
                    st_d  = ST_SKIP;
                end
            end else if (st_q == ST_RDATA) begin
                drv_d = ~shf_q[7];
            end
        end
        if (!ce_i) begin
            // frozen: every register holds
            scl_d  = scl_q;
            sda_d  = sda_q;
            st_d   = st_q;
            shf_d  = shf_q;
            cnt_d  = cnt_q;
            slot_d = slot_q;
            drv_d  = drv_q;
            cmd_d  = cmd_q;
            pend_d = pend_q;
            wdat_d = wdat_q;
            stb_d  = stb_q;
        end
    end

    // registers of the byte engine
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_q  <= 3'h7;
            sda_q  <= 3'h7;
            st_q   <= ST_IDLE;
            shf_q  <= 8'h00;
            cnt_q  <= 4'h0;
            slot_q <= 1'b0;
            drv_q  <= 1'b0;
            cmd_q  <= 1'b0;
            pend_q <= 1'b0;
            wdat_q <= 8'h00;
            stb_q  <= 1'b0;
        end else begin
            scl_q  <= scl_d;
            sda_q  <= sda_d;
            st_q   <= st_d;
            shf_q  <= shf_d;
            cnt_q  <= cnt_d;
            slot_q <= slot_d;
            drv_q  <= drv_d;
            cmd_q  <= cmd_d;
            pend_q <= pend_d;
            wdat_q <= wdat_d;
            stb_q  <= stb_d;
        end
    end

    // open-drain data pin, enable low while pulling low
    assign sda_o       = 1'b0;
    assign sda_oe_n_o  = ~drv_q;
    assign bus.wr_stb  = stb_q;
    assign bus.wr_data = wdat_q;
endmodule

/* testbench/pmbus_host_model.sv */
// bit-level management bus host that drives the target's pins
module pmbus_host_model (
    // wired data level seen on the bus
    input  wire logic sda_i,
    // host pins, a 1 on data releases the line
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 80; // half of the 160 ns link period

    // idle bus: clock stands high, data released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // start or repeated start, data falls while clock high
    task automatic start();
        sda_o = 1'b1;
        #(HALF/2) scl_o = 1'b1;
        #(HALF/2) sda_o = 1'b0;
        #(HALF/2) scl_o = 1'b0;
    endtask

    // stop, data rises while clock high, then clock stands
    task automatic stop();
        sda_o = 1'b0;
        #(HALF/2) scl_o = 1'b1;
        #(HALF/2) sda_o = 1'b1;
        #(HALF);
    endtask

    // one bit out, the wired level sampled mid high phase
    task automatic xfer_bit(input logic b, output logic r);
        sda_o = b;
        #(HALF/2) scl_o = 1'b1;
        #(HALF/2) r = sda_i;
        #(HALF/2) scl_o = 1'b0;
        #(HALF/2);
    endtask

    // eight bits msb first plus the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                             output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) xfer_bit(tx[i], rx[i]);
        xfer_bit(ack_in, ack);
    endtask

    // write byte at the operation command code
    task automatic write_op(input logic [6:0] a, input logic [7:0] d,
                            output logic ok);
        logic [7:0] rx;
        logic       n1, n2, n3;
        start();
        xfer_byte({a, 1'b0}, 1'b1, rx, n1);
        xfer_byte(8'h01, 1'b1, rx, n2);
        xfer_byte(d, 1'b1, rx, n3);
        stop();
        ok = !(n1 | n2 | n3);
    endtask

    // read byte: command, repeated start, data, nack
    task automatic read_op(input logic [6:0] a, output logic [7:0] d);
        logic [7:0] rx;
        logic       n;
        start();
        xfer_byte({a, 1'b0}, 1'b1, rx, n);
        xfer_byte(8'h01, 1'b1, rx, n);
        start();
        xfer_byte({a, 1'b1}, 1'b1, rx, n);
        xfer_byte(8'hff, 1'b1, d, n);
        stop();
    endtask
endmodule

/* testbench/operation_command_decoder_bench.sv */
// self-checking bench of the operation command decoder
module operation_command_decoder_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import opcmd_pkg::*;

    logic              clk_sys_i = 1'b0; // system clock
    logic              nrst_i = 1'b0;    // reset, active low
    logic              scl, sda_h;       // host pins
    wire logic         sda_w;            // wired data level
    logic              sda_o, sda_oe_n_o, alert_o, alert_oe_n_o;
    logic              ce = 1'b1;        // clock enable
    logic              clr = 1'b0;       // status clear
    logic              respect = 1'b1;   // command respected
    logic              start_ok = 1'b0;  // other start conditions
    logic [HOLD_W-1:0] hold = 16'h0028;  // turn-off hold cycles
    logic              at_zero = 1'b0;   // output at zero volts
    logic              conv, hiz, ramp, ign, inval;
    target_sel_t       tsel;
    int                bad_count = 0;
    int                num_checks = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;
    // open drain with pull-up, low if either party pulls
    assign sda_w = sda_h & (sda_oe_n_o | sda_o);

    pmbus_host_model host (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));

    operation_command_decoder uut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .alert_o(alert_o),
        .alert_oe_n_o(alert_oe_n_o), .status_clear_i(clr),
        .cmd_respect_i(respect), .start_ok_i(start_ok),
        .hold_cycles_i(hold), .out_at_zero_i(at_zero),
        .convert_o(conv), .stage_hiz_o(hiz), .ramp_down_o(ramp),
        .target_sel_o(tsel), .fault_ignore_o(ign),
        .invalid_data_o(inval));

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // wait n edges, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // write the byte, expect acknowledge, let it settle
    task automatic wr(input logic [7:0] d);
        logic ok;
        host.write_op(BUS_ADDR_DEF, d, ok);
        check(ok, 1'b1);
        cyc(4);
    endtask

    // read back the byte and compare
    task automatic rd(input logic [7:0] exp);
        logic [7:0] d;
        host.read_op(BUS_ADDR_DEF, d);
        check(d, exp);
    endtask

    // reset values at the pins and in the byte
    task automatic t_reset();
        check({conv, hiz, ramp, ign, inval}, 8'h08);
        check(tsel, 8'h00);
        check(alert_oe_n_o, 1'b1);
        check({sda_o, alert_o}, 8'h00);
        rd(8'h00);
    endtask

    // every listed margin code with enable set
    task automatic t_margins();
        logic [3:0] code [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
        logic [1:0] tg [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        logic       ig [7] = '{0, 0, 0, 1, 0, 1, 0};
        for (int i = 0; i < 7; i++) begin
            wr({2'b10, code[i], 2'b00});
            check(tsel, tg[i]);
            check(ign, ig[i]);
            rd({2'b10, code[i], 2'b00});
        end
        check(conv, 1'b0);
    endtask

    // ignore-fault margins with enable clear act on faults
    task automatic t_ignore_gated();
        wr(8'h14);
        check({tsel, ign}, 8'h02);
        wr(8'h24);
        check({tsel, ign}, 8'h04);
    endtask

    // unlisted codes and nonzero low bits are refused and flagged
    task automatic t_reject();
        wr(8'h8c);
        check({inval, alert_oe_n_o}, 8'h02);
        rd(8'h24);
        clr = 1'b1;
        cyc(2);
        clr = 1'b0;
        check({inval, alert_oe_n_o}, 8'h01);
        wr(8'h81);
        check(inval, 1'b1);
        rd(8'h24);
        clr = 1'b1;
        cyc(2);
        clr = 1'b0;
    endtask

    // a foreign address is not acknowledged and changes nothing
    task automatic t_wrong_addr();
        logic ok;
        host.write_op(BUS_ADDR_DEF ^ 7'h01, 8'h80, ok);
        check(ok, 1'b0);
        rd(8'h24);
    endtask

    // start needs the other conditions, immediate turn-off
    task automatic t_hard_off();
        start_ok = 1'b1;
        wr(8'h80);
        check({conv, hiz}, 8'h02);
        start_ok = 1'b0;
        cyc(2);
        check(conv, 1'b0);
        start_ok = 1'b1;
        cyc(2);
        check(conv, 1'b1);
        // frozen clock enable holds the running state
        ce = 1'b0;
        start_ok = 1'b0;
        cyc(3);
        check(conv, 1'b1);
        ce = 1'b1;
        cyc(2);
        check(conv, 1'b0);
        start_ok = 1'b1;
        cyc(2);
        check(conv, 1'b1);
        wr(8'h00);
        check({conv, hiz, ramp}, 8'h02);
    endtask

    // soft turn-off: hold, ramp, stop at zero
    task automatic t_soft_off();
        wr(8'hc0);
        wr(8'h40);
        check({conv, ramp}, 8'h02);
        cyc(40);
        check({conv, ramp}, 8'h03);
        at_zero = 1'b1;
        cyc(2);
        check({conv, hiz, ramp}, 8'h02);
        at_zero = 1'b0;
    endtask

    // enable bit ignored while commands are not respected
    task automatic t_respect();
        respect = 1'b0;
        cyc(3);
        check(conv, 1'b1);
        respect = 1'b1;
        cyc(3);
        // enable bit obeyed again, soft bit still set: hold phase
        check({conv, ramp}, 8'h02);
        cyc(45);
        check({conv, ramp}, 8'h03);
        at_zero = 1'b1;
        cyc(2);
        check(conv, 1'b0);
        at_zero = 1'b0;
    endtask

    // counts and verdict, the single end of the run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #400us;
        bad_count++;
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1 nrst_i = 1'b1;
        cyc(4);
        t_reset();
        t_margins();
        t_ignore_gated();
        t_reject();
        t_wrong_addr();
        t_hard_off();
        t_soft_off();
        t_respect();
        wrap_up();
    end
endmodule
